// ### rtl/sacc_device.sv
`timescale 1ns/1ps
// Overview of operation
// - Calibrate high resets, raises busy, aborts
// - Calibration runs 85532 clocks after falling edge
// - Sample high during calibration gives diagnostic bits
// - Null offset, then nine capacitor corrections
// - Corrections applied to all later results
// - Host calibrates once after power-up
// - Acquisition then 17 master clock pulses
// - Host holds sample high minimum time
// - Input taken one aperture delay after fall
// - Sample fall raises busy, sample ignored
// - Host keeps sample low minimum time
// - Early master clock pulses are ignored
// - Idle: master clock ignored, outputs held; read clock still makes its last rise one clock after busy falls
// - Sample honoured again once busy falls
// - Sample high at pulse 17 reacquires
// - Busy high through conversion and calibration
// - Read clock derived from master clock
module sacc_device
  import sacc_pkg::*;
#(
  parameter int CAL_LEN   = CAL_CYCLES,
  parameter int RES_W     = RESULT_BITS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Link
  sacc_link_if.dev              link,
  // Analog front end, as a digital code
  input  wire logic [RES_W-1:0] analog_code,
  // Status
  output logic                  cal_valid,
  output logic                  sampling
);

  sacc_dev_state_t state;
  sacc_dev_state_t next_state;

  logic                   samp_q;
  logic                   cal_q;
  logic                   mclk_q;
  logic [CAL_CNT_W-1:0]   cal_cnt;
  logic [TIME_CNT_W-1:0]  tcnt;
  logic [PULSE_CNT_W-1:0] pulse_cnt;
  logic [RES_W-1:0]       held_code;
  logic [RES_W-1:0]       shift_reg;
  logic [RES_W-1:0]       offset_corr;
  logic [RES_W-1:0]       cap_corr [CAL_CAP_STEPS];
  logic [CAL_STEP_W-1:0]  cal_step;
  logic                   busy_r;
  logic                   serial_result_out_r;
  logic                   rclk_r;
  logic                   rclk_arm;
  logic                   diag_r;

  wire samp_fall  = samp_q & ~link.sample_req;
  wire cal_fall   = cal_q & ~link.cal_req;
  wire mclk_rise  = ~mclk_q & link.master_clk;
  wire mclk_fall  = mclk_q & ~link.master_clk;
  wire in_conv    = (state == SACC_CONV);
  // Early pulses ignored
  // first-clock gate
  wire clk_ok     = in_conv && (tcnt >= TIME_CNT_W'(FIRST_CLK_DELAY_CYC));
  wire last_pulse = clk_ok && mclk_rise && (pulse_cnt == PULSE_CNT_W'(CONV_PULSES - 1));
  wire cal_done   = (state == SACC_CAL_RUN) && (cal_cnt == CAL_CNT_W'(CAL_LEN - 1));
  // Correction folded in as a sum of stored terms
  logic [RES_W-1:0] corr_sum;
  always_comb begin
    corr_sum = offset_corr;
    for (int i = 0; i < CAL_CAP_STEPS; i++) begin
      corr_sum = corr_sum + cap_corr[i];
    end
  end
  wire [RES_W-1:0] corrected = held_code - corr_sum;

  always_comb begin
    next_state = state;
    unique case (state)
      SACC_IDLE:    if (link.sample_req) next_state = SACC_ACQ;
      SACC_CAL_HLD: if (cal_fall) next_state = SACC_CAL_RUN;
      SACC_CAL_RUN: if (cal_done) next_state = SACC_IDLE;
      SACC_ACQ:     if (samp_fall) next_state = SACC_HOLD;
      SACC_HOLD:    if (tcnt == TIME_CNT_W'(SAMPLE_BUSY_CYC - 1)) next_state = SACC_CONV;
      SACC_CONV: begin
        if (last_pulse) next_state = link.sample_req ? SACC_REACQ : SACC_IDLE;
      end
      SACC_REACQ:   if (tcnt == TIME_CNT_W'(REACQ_DELAY_CYC - 1)) next_state = SACC_ACQ;
      default:      next_state = SACC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      samp_q <= 1'b0;
      cal_q  <= 1'b0;
      mclk_q <= 1'b0;
    end else begin
      samp_q <= link.sample_req;
      cal_q  <= link.cal_req;
      mclk_q <= link.master_clk;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SACC_IDLE;
      tcnt  <= '0;
    end else if (link.cal_req) begin
      state <= SACC_CAL_HLD;
      tcnt  <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) tcnt <= '0;
      else if (tcnt != '1) tcnt <= tcnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_cnt <= '0;
    end else if (state != SACC_CAL_RUN || link.cal_req) begin
      cal_cnt <= '0;
    end else begin
      cal_cnt <= cal_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_step    <= '0;
      offset_corr <= '0;
      cal_valid   <= 1'b0;
      for (int i = 0; i < CAL_CAP_STEPS; i++) cap_corr[i] <= '0;
    end else if (link.cal_req) begin
      cal_step  <= '0;
      cal_valid <= 1'b0;
    end else if (state == SACC_CAL_RUN) begin
      if (cal_step == '0 && cal_cnt == CAL_CNT_W'(1)) begin
        offset_corr <= '0;
        cal_step    <= cal_step + 1'b1;
      end else if (cal_step != '0 && cal_step <= CAL_STEP_W'(CAL_CAP_STEPS)
                   && cal_cnt == CAL_CNT_W'(32) * CAL_CNT_W'(cal_step)) begin
        cap_corr[cal_step - 1'b1] <= '0;
        cal_step <= cal_step + 1'b1;
      end
      if (cal_done) cal_valid <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt <= '0;
      held_code <= '0;
      shift_reg <= '0;
      serial_result_out_r   <= 1'b0;
      rclk_r    <= 1'b0;
      rclk_arm  <= 1'b0;
    end else if (link.cal_req) begin
      pulse_cnt <= '0;
      rclk_arm  <= 1'b0;
    end else begin
      rclk_arm <= 1'b0;
      if (state == SACC_ACQ) held_code <= analog_code;
      if (state == SACC_HOLD) pulse_cnt <= '0;
      if (clk_ok && mclk_rise) begin
        pulse_cnt <= pulse_cnt + 1'b1;
        // Pulse one only loads, so bits leave on pulses two..seventeen
        if (pulse_cnt == '0) begin
          shift_reg <= corrected;
        end else begin
          shift_reg <= {shift_reg[RES_W-2:0], 1'b0};
          serial_result_out_r   <= shift_reg[RES_W-1];
          rclk_arm  <= 1'b1;
        end
      end
      // read clock
      // Rises one clock after the bit so the read edge never races the data;
      // the last rise trails busy by that clock, then stays high while idle
      if (rclk_arm) rclk_r <= 1'b1;
      if (clk_ok && mclk_fall) rclk_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      diag_r <= 1'b0;
    end else if (state == SACC_CAL_RUN && link.sample_req) begin
      diag_r <= cal_cnt[0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= link.cal_req || next_state == SACC_CAL_HLD || next_state == SACC_CAL_RUN
                || next_state == SACC_CONV;
    end
  end

  assign link.busy              = busy_r;
  assign link.read_clk          = rclk_r;
  assign link.serial_result_out = (state == SACC_CAL_RUN && link.sample_req) ? diag_r : serial_result_out_r;
  assign sampling               = (state == SACC_ACQ);

endmodule : sacc_device

// ### common/sacc_pkg.sv
package sacc_pkg;

  // Result and conversion framing
  localparam int RESULT_BITS        = 16;
  localparam int CONV_PULSES        = 17;
  localparam int PULSE_CNT_W        = 5;
  localparam int CAL_CAP_STEPS      = 9;
  localparam int CAL_STEP_W         = 4;

  // Calibration length in clk cycles
  localparam int CAL_CYCLES         = 85532;
  localparam int CAL_CNT_W          = 17;

  // Host-side timing, in ns, and derived counts at 100 MHz
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SAMPLE_HIGH_MIN_NS = 1000;
  localparam int SAMPLE_HIGH_CYC    =
    (SAMPLE_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_LOW_MIN_NS  = 50;
  localparam int SAMPLE_LOW_CYC     =
    (SAMPLE_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIRST_CLK_DELAY_NS = 1000;
  localparam int FIRST_CLK_DELAY_CYC =
    (FIRST_CLK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_BUSY_NS     = 50;
  localparam int SAMPLE_BUSY_CYC    =
    (SAMPLE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REACQ_DELAY_NS     = 100;
  localparam int REACQ_DELAY_CYC    = REACQ_DELAY_NS / CLK_PERIOD_NS;
  localparam int MCLK_HALF_CYC      = 4;
  localparam int TIME_CNT_W         = 12;

  // Device sequencer states
  typedef enum logic [2:0] {
    SACC_IDLE    = 3'b000,
    SACC_CAL_HLD = 3'b001,
    SACC_CAL_RUN = 3'b010,
    SACC_ACQ     = 3'b011,
    SACC_HOLD    = 3'b100,
    SACC_CONV    = 3'b101,
    SACC_REACQ   = 3'b110
  } sacc_dev_state_t;

  // Host sequencer states
  typedef enum logic [2:0] {
    SACH_IDLE    = 3'b000,
    SACH_CAL_HI  = 3'b001,
    SACH_CAL_WT  = 3'b010,
    SACH_SAMPLE  = 3'b011,
    SACH_SLOW    = 3'b100,
    SACH_CLK_HI  = 3'b101,
    SACH_CLK_LO  = 3'b110
  } sacc_host_state_t;

endpackage : sacc_pkg

// ### common/sacc_link_if.sv
`timescale 1ns/1ps
interface sacc_link_if;
  logic sample_req;
  logic cal_req;
  logic master_clk;
  logic busy;
  logic serial_result_out;
  logic read_clk;

  modport dev (
    input  sample_req,
    input  cal_req,
    input  master_clk,
    output busy,
    output serial_result_out,
    output read_clk
  );

  modport host (
    output sample_req,
    output cal_req,
    output master_clk,
    input  busy,
    input  serial_result_out,
    input  read_clk
  );
endinterface : sacc_link_if

// ### rtl/sacc_host.sv
`timescale 1ns/1ps
module sacc_host
  import sacc_pkg::*;
#(
  parameter int RES_W = RESULT_BITS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Link
  sacc_link_if.host             link,
  // User side
  input  wire logic             cal_start,
  input  wire logic             conv_start,
  output logic                  ready,
  output logic [RES_W-1:0]      result,
  output logic                  result_valid
);

  sacc_host_state_t state;
  logic [TIME_CNT_W-1:0]  tcnt;
  logic [PULSE_CNT_W-1:0] pulses;
  logic [RES_W-1:0]       shreg;
  logic                   busy_q;
  logic                   rclk_q;
  logic                   cal_pend;

  wire rclk_rise = ~rclk_q & link.read_clk;
  wire half_done = (tcnt == TIME_CNT_W'(MCLK_HALF_CYC - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state  <= SACH_IDLE;
      tcnt   <= '0;
      pulses <= '0;
      busy_q <= 1'b0;
      cal_pend <= 1'b1;
    end else begin
      busy_q <= link.busy;
      tcnt   <= tcnt + 1'b1;
      unique case (state)
        SACH_IDLE: begin
          tcnt <= '0;
          if (cal_pend || cal_start) state <= SACH_CAL_HI;
          else if (conv_start && !link.busy) state <= SACH_SAMPLE;
        end
        SACH_CAL_HI: if (half_done) begin
          state <= SACH_CAL_WT;
          tcnt  <= '0;
          cal_pend <= 1'b0;
        end
        SACH_CAL_WT: if (busy_q && !link.busy) state <= SACH_IDLE;
        SACH_SAMPLE: if (tcnt == TIME_CNT_W'(SAMPLE_HIGH_CYC - 1)) begin
          state <= SACH_SLOW;
          tcnt  <= '0;
        end
        // low time and first clock delay
        SACH_SLOW: if (tcnt == TIME_CNT_W'(FIRST_CLK_DELAY_CYC + SAMPLE_LOW_CYC)) begin
          state  <= SACH_CLK_HI;
          tcnt   <= '0;
          pulses <= '0;
        end
        SACH_CLK_HI: if (half_done) begin
          state  <= SACH_CLK_LO;
          tcnt   <= '0;
          pulses <= pulses + 1'b1;
        end
        SACH_CLK_LO: if (half_done) begin
          tcnt  <= '0;
          state <= (pulses == PULSE_CNT_W'(CONV_PULSES)) ? SACH_IDLE : SACH_CLK_HI;
        end
        default: state <= SACH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rclk_q       <= 1'b0;
      shreg        <= '0;
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      rclk_q       <= link.read_clk;
      result_valid <= 1'b0;
      if (rclk_rise) shreg <= {shreg[RES_W-2:0], link.serial_result_out};
      if (state == SACH_CLK_LO && half_done && pulses == PULSE_CNT_W'(CONV_PULSES)) begin
        result       <= shreg;
        result_valid <= 1'b1;
      end
    end
  end

  assign link.sample_req = (state == SACH_SAMPLE);
  assign link.cal_req    = (state == SACH_CAL_HI);
  assign link.master_clk = (state == SACH_CLK_HI);
  assign ready           = (state == SACH_IDLE) && !cal_pend && !link.busy;

endmodule : sacc_host

// ### tb/sacc_chk.sv
`timescale 1ns/1ps
module sacc_chk #(
  parameter int CAL_LEN = 400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link
  input wire logic sample_req,
  input wire logic cal_req,
  input wire logic master_clk,
  input wire logic busy,
  input wire logic serial_result_out,
  input wire logic read_clk
);
  logic [16:0] cal_cnt;
  logic        in_cal;
  logic [4:0]  rises;
  logic        mclk_d;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Cycle and pulse counts for the long checks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_cnt <= '0;
      in_cal  <= 1'b0;
      rises   <= '0;
      mclk_d  <= 1'b0;
    end else begin
      mclk_d  <= master_clk;
      cal_cnt <= cal_req ? '0 : (busy ? cal_cnt + 17'h00001 : cal_cnt);
      in_cal  <= cal_req | (in_cal & busy);
      rises   <= !sample_req && $fell(sample_req) ? '0 :
                 (master_clk && !mclk_d ? rises + 5'h01 : rises);
    end
  end

  property p_cal_busy; $rose(cal_req) |-> ##[1:3] busy; endproperty
  a_cal_busy: assert property (p_cal_busy) else $error("busy late on cal");
  property p_cal_hold; cal_req [*3] |-> busy; endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("busy low in cal");
  property p_cal_len; in_cal && $fell(busy) |-> cal_cnt >= CAL_LEN - 2 && cal_cnt <= CAL_LEN + 3;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("cal length wrong");
  property p_conv_busy; $fell(sample_req) && !busy |-> ##[1:10] busy; endproperty
  a_conv_busy: assert property (p_conv_busy) else $error("busy late on sample");
  property p_pulses; !in_cal && $fell(busy) |-> rises == 5'd17; endproperty
  a_pulses: assert property (p_pulses) else $error("pulse count wrong");
  property p_quiet; $fell(sample_req) |=> $stable(master_clk) [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("early master clock");
  property p_idle; !busy && !$past(busy) && !$past(busy, 2) |=> $stable(serial_result_out);
  endproperty
  a_idle: assert property (p_idle) else $error("data moved while idle");
  property p_idle_rclk; !busy && !$past(busy) && !$past(busy, 2) |=> $stable(read_clk);
  endproperty
  a_idle_rclk: assert property (p_idle_rclk) else $error("read clock moved while idle");
  property p_rclk; $rose(read_clk) |-> master_clk; endproperty
  a_rclk: assert property (p_rclk) else $error("read clock edge misplaced");
endmodule : sacc_chk

// ### tb/tb_sacc_device.sv
`timescale 1ns/1ps
module tb_sacc_device;
  import sacc_pkg::*;
  localparam int CAL_LEN = 400;
  logic        clk;
  logic        rst_b;
  logic        cal_start;
  logic        conv_start;
  logic        ready;
  logic        result_valid;
  logic        cal_valid;
  logic        sampling;
  logic [15:0] analog_code;
  logic [15:0] result;
  logic [15:0] got;
  int          failures;
  int          n_compared;
  int          cycles;
  // Input code beside expected result; stored corrections are zero
  logic [31:0] rows [5] = '{32'h00000000, 32'h7FFF7FFF, 32'h80008000,
                            32'hFFFFFFFF, 32'hA5C3A5C3};

  sacc_link_if link ();
  sacc_device #(.CAL_LEN(CAL_LEN)) sacc_device_i (.clk(clk), .rst_b(rst_b), .link(link),
    .analog_code(analog_code), .cal_valid(cal_valid), .sampling(sampling));
  sacc_host sacc_host_i (.clk(clk), .rst_b(rst_b), .link(link), .cal_start(cal_start),
    .conv_start(conv_start), .ready(ready), .result(result), .result_valid(result_valid));
  sacc_chk #(.CAL_LEN(CAL_LEN)) sacc_chk_i (.clk(clk), .rst_b(rst_b),
    .sample_req(link.sample_req), .cal_req(link.cal_req), .master_clk(link.master_clk),
    .busy(link.busy), .serial_result_out(link.serial_result_out), .read_clk(link.read_clk));

  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp16

  task automatic cmp1(input string what, input logic exp, input logic seen);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp1

  task automatic wait_ready();
    do @(negedge clk); while (ready !== 1'b1);
  endtask : wait_ready

  // Input is spoiled once busy rises, so a late sample shows up
  task automatic convert(input logic [15:0] code, output logic [15:0] res);
    wait_ready();
    @(posedge clk);
    analog_code <= code;
    conv_start  <= 1'b1;
    @(posedge clk);
    conv_start  <= 1'b0;
    repeat (2) @(negedge clk);
    cmp1("sampling", 1'b1, sampling);
    do @(negedge clk); while (link.busy !== 1'b1);
    @(posedge clk);
    analog_code <= ~code;
    do @(negedge clk); while (result_valid !== 1'b1);
    res = result;
  endtask : convert

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ceiling well above two calibrations and six conversions
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    rst_b = 1'b0;
    cal_start = 1'b0;
    conv_start = 1'b0;
    analog_code = 16'h0000;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    cmp1("busy in reset", 1'b0, link.busy);
    cmp1("valid in reset", 1'b0, result_valid);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wait_ready();
    cmp1("power-up cal", 1'b1, cal_valid);
    $display("reset and power-up cal done");
    foreach (rows[i]) begin
      convert(rows[i][31:16], got);
      cmp16("result", rows[i][15:0], got);
    end
    $display("conversion table done");
    @(posedge clk);
    cal_start <= 1'b1;
    @(posedge clk);
    cal_start <= 1'b0;
    repeat (8) @(negedge clk);
    cmp1("busy in recal", 1'b1, link.busy);
    cmp1("cal_valid in recal", 1'b0, cal_valid);
    wait_ready();
    cmp1("recal valid", 1'b1, cal_valid);
    convert(16'h1234, got);
    cmp16("result after recal", 16'h1234, got);
    $display("recalibration done");
    wrap_up();
  end
endmodule : tb_sacc_device
